// file: rtl/sfm_pkg.sv
// Constants, command and answer types for the serial flash master port.
// Assumes a link clock of known period feeding the serial engine.
package sfm_pkg;

  // Serial clock limits, oscillator tolerance already included
  localparam int F_SCK_MAX_KHZ   = 36000;
  localparam int F_SCK_MIN_KHZ   = 1400;
  localparam int PS_PER_MS       = 1000000000;
  // Link clock period, 64 ns
  localparam int LINK_PERIOD_PS  = 64000;
  // System clock period, 10 ns
  localparam int SYS_PERIOD_PS   = 10000;
  // Link periods the link side stays in reset after a system reset
  localparam int RST_LINK_CYC    = 8;
  // Fewest link cycles per half period so the three-stage pin sampler
  // still catches data launched after the previous falling edge
  localparam int SYNC_MARGIN     = 3;

  // Largest flash: 128 Mbit, 24 address bits; smaller parts ignore the top
  localparam int ADDR_W          = 24;
  localparam int LEN_W           = 16;
  localparam int DIV_W           = 4;
  localparam int CNT_W           = 20;
  localparam int ADDR_BYTES      = 3;

  localparam logic [7:0] IDLE_FILL = 8'hFF;

  typedef struct packed {
    logic [7:0]        opcode;
    logic [ADDR_W-1:0] addr;
    logic              addr_en;
    logic [7:0]        wdata;
    logic              wr_en;
    logic [LEN_W-1:0]  rd_len;
    logic [DIV_W-1:0]  half_div;
  } sfm_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } sfm_rx_t;

  typedef enum logic [1:0] {
    SFM_IDLE,
    SFM_SHIFT,
    SFM_GAP
  } sfm_state_t;

  // Bytes sent before any read byte
  function automatic logic [2:0] sfm_tx_count(input sfm_cmd_t c);
    sfm_tx_count = 3'(1 + (c.addr_en ? ADDR_BYTES : 0) + (c.wr_en ? 1 : 0));
  endfunction

  // Byte at position idx of the outgoing stream
  function automatic logic [7:0] sfm_tx_byte(input sfm_cmd_t c,
                                             input logic [CNT_W-4:0] idx);
    logic [2:0] a_end;
    a_end = c.addr_en ? 3'(1 + ADDR_BYTES) : 3'(1);
    if (idx == '0)
      sfm_tx_byte = c.opcode;
    else if (c.addr_en && idx < CNT_W'(1 + ADDR_BYTES))
      sfm_tx_byte = c.addr[8*(ADDR_BYTES - 32'(idx)) +: 8];
    else if (c.wr_en && idx == (CNT_W-3)'(a_end))
      sfm_tx_byte = c.wdata;
    else
      sfm_tx_byte = IDLE_FILL;
  endfunction

endpackage

// file: rtl/sfm_sync3.sv
// Three-stage synchroniser; output moves once stages two and three agree.
// Assumes inputs are levels from another domain or a pin.
`timescale 1ns/1ps
module sfm_sync3 #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clock,
  // Asynchronous levels in, filtered levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Stage one feeds stage two only
  always_ff @(posedge clock) begin
    stage1 <= async_in;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // Per bit: accept a change only when the late stages agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clock) begin
        if (stage2[g] == stage3[g]) begin
          sync_out[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule

// file: rtl/sfm_port.sv
// Serial flash master port: command side on clock, serial engine on
// link_clock. Assumes the flash works in clock-idle-high framing.
`timescale 1ns/1ps
// Behaviour
// - Serial clock kept between 1.4 and 36 MHz
// - Any flash from 1 to 128 Mbit
// - Data out and select change on falls
// - Incoming data sampled on falling edges
module sfm_port #(
  parameter int LINK_PS = sfm_pkg::LINK_PERIOD_PS
) (
  // System clock, reset and freeze
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clock_en,
  // Link clock for the serial engine
  input  wire logic             link_clock,
  // Command request
  input  wire logic             cmd_valid,
  input  wire sfm_pkg::sfm_cmd_t cmd,
  output logic                  cmd_ready,
  // Read bytes and end of transaction
  output sfm_pkg::sfm_rx_t      rx,
  output logic                  done,
  // Flash pins
  output logic                  flash_clk,
  output logic                  flash_chip_select_n,
  output logic                  flash_mosi,
  input  wire logic             flash_miso
);
  import sfm_pkg::*;

  // Half period limits in link cycles, derived from frequency limits
  localparam int HALF_MIN_RAW =
    (PS_PER_MS / (2 * F_SCK_MAX_KHZ) + LINK_PS - 1) / LINK_PS;
  localparam int HALF_MIN_I =
    (HALF_MIN_RAW < SYNC_MARGIN) ? SYNC_MARGIN : HALF_MIN_RAW;
  localparam int HALF_MAX_RAW = PS_PER_MS / (2 * F_SCK_MIN_KHZ) / LINK_PS;
  localparam int HALF_MAX_I =
    (HALF_MAX_RAW < HALF_MIN_I) ? HALF_MIN_I : HALF_MAX_RAW;
  localparam logic [DIV_W-1:0] HALF_MIN = DIV_W'(HALF_MIN_I);
  localparam logic [DIV_W-1:0] HALF_MAX = DIV_W'(HALF_MAX_I);
  // System cycles that keep the link side in reset after sys_rst
  localparam int RST_HOLD_I =
    (RST_LINK_CYC * LINK_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int HOLD_W = $clog2(RST_HOLD_I + 1);
  localparam logic [HOLD_W-1:0] RST_HOLD = HOLD_W'(RST_HOLD_I);

  // ---------------- system domain ----------------
  sfm_cmd_t   req_hold;
  logic       req_tgl;
  logic       rx_seen;
  logic       done_seen;
  logic [1:0] back_sync;
  logic       rx_tgl;
  logic       done_tgl;
  logic [7:0] rx_byte;
  logic [HOLD_W-1:0] rst_hold;
  logic       rst_to_link;

  wire rst_hold_on = (rst_hold != '0);
  wire take_cmd = cmd_valid & cmd_ready;
  // Answers ignored while the link side is still coming out of reset
  wire rx_arrive = (back_sync[0] ^ rx_seen) & ~rst_hold_on;
  wire done_arrive = (back_sync[1] ^ done_seen) & ~rst_hold_on;

  // Stretch reset for the link side; a short pulse can fall between two
  // link edges and would never pass the synchroniser's agreement check
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rst_hold    <= RST_HOLD;
      rst_to_link <= 1'b1;
    end else if (clock_en) begin
      rst_hold    <= rst_hold_on ? rst_hold - HOLD_W'(1) : '0;
      rst_to_link <= rst_hold_on;
    end
  end

  // Toggles from the serial engine
  sfm_sync3 #(.W(2)) u_back_sync (
    .clock    (clock),
    .async_in ({done_tgl, rx_tgl}),
    .sync_out (back_sync)
  );

  // Command hand-off and answer pulses; one command in flight at a time
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_hold  <= '0;
      req_tgl   <= 1'b0;
      cmd_ready <= 1'b1;
      rx_seen   <= 1'b0;
      done_seen <= 1'b0;
      rx        <= '0;
      done      <= 1'b0;
    end else if (clock_en) begin
      rx.valid <= rx_arrive;
      done     <= done_arrive;
      rx_seen  <= back_sync[0];
      done_seen <= back_sync[1];
      if (rx_arrive) begin
        rx.data <= rx_byte; // Stable: engine changes it only per byte
      end
      if (take_cmd) begin
        req_hold  <= cmd;
        req_tgl   <= ~req_tgl;
        cmd_ready <= 1'b0;
      end else if (done_arrive) begin
        cmd_ready <= 1'b1;
      end
    end
  end

  // ---------------- link domain ----------------
  logic [3:0] fwd_sync;
  wire link_req  = fwd_sync[0];
  wire link_rst  = fwd_sync[1];
  wire link_ce   = fwd_sync[2];
  wire miso_s    = fwd_sync[3];

  // Request toggle, reset, freeze and the data pin into the link domain
  sfm_sync3 #(.W(4)) u_fwd_sync (
    .clock    (link_clock),
    .async_in ({flash_miso, clock_en, rst_to_link, req_tgl}),
    .sync_out (fwd_sync)
  );

  sfm_state_t       state;
  sfm_cmd_t         cmd_l;
  logic [DIV_W-1:0] half;
  logic [DIV_W-1:0] hc;
  logic [CNT_W-1:0] k;
  logic [CNT_W-1:0] nbits;
  logic             req_seen;
  logic [7:0]       shift;

  // Stream decoding
  wire [2:0]       ntx     = sfm_tx_count(req_hold);
  wire [2:0]       ntx_l   = sfm_tx_count(cmd_l);
  wire [CNT_W-1:0] k_next  = k + CNT_W'(1);
  wire [7:0]       byte_0  = sfm_tx_byte(req_hold, '0);
  wire [7:0]       byte_n  = sfm_tx_byte(cmd_l, k_next[CNT_W-1:3]);
  wire             half_end = (hc == half - DIV_W'(1));
  wire             last_fall = (k_next == nbits);
  wire [CNT_W-4:0] done_idx = k_next[CNT_W-1:3] - (CNT_W-3)'(1);
  wire             rx_byte_done = (k_next[2:0] == 3'h0)
                                  && (done_idx >= (CNT_W-3)'(ntx_l));
  // Clamp the requested rate into the legal window
  wire [DIV_W-1:0] half_req =
    (req_hold.half_div < HALF_MIN) ? HALF_MIN :
    (req_hold.half_div > HALF_MAX) ? HALF_MAX : req_hold.half_div;
  // Full stream length; read length is unbounded by flash size
  wire [CNT_W-1:0] nbits_req =
    CNT_W'({(CNT_W-3)'(ntx) + (CNT_W-3)'(req_hold.rd_len), 3'h0});

  // Serial engine; idle with clock high, select high
  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      state     <= SFM_IDLE;
      cmd_l     <= '0;
      half      <= HALF_MIN;
      hc        <= '0;
      k         <= '0;
      nbits     <= '0;
      req_seen  <= 1'b0;
      shift     <= '0;
      rx_byte   <= '0;
      rx_tgl    <= 1'b0;
      done_tgl  <= 1'b0;
      flash_clk <= 1'b1;
      flash_chip_select_n <= 1'b1;
      flash_mosi <= 1'b1;
    end else if (link_ce) begin
      case (state)
        SFM_IDLE: begin
          if (link_req != req_seen) begin
            // First fall: select and first bit change together
            req_seen  <= link_req;
            cmd_l     <= req_hold;
            half      <= half_req;
            nbits     <= nbits_req;
            hc        <= '0;
            k         <= '0;
            flash_clk <= 1'b0;
            flash_chip_select_n <= 1'b0;
            flash_mosi <= byte_0[7];
            state     <= SFM_SHIFT;
          end
        end
        SFM_SHIFT: begin
          hc <= half_end ? '0 : hc + DIV_W'(1);
          if (half_end && !flash_clk) begin
            flash_clk <= 1'b1;
          end else if (half_end) begin
            flash_clk <= 1'b0;
            shift     <= {shift[6:0], miso_s};
            k         <= k_next;
            if (rx_byte_done) begin
              rx_byte <= {shift[6:0], miso_s};
              rx_tgl  <= ~rx_tgl;
            end
            if (last_fall) begin
              flash_chip_select_n <= 1'b1;
              state <= SFM_GAP;
            end else begin
              flash_mosi <= byte_n[3'h7 - k_next[2:0]];
            end
          end
        end
        SFM_GAP: begin
          // Deselect gap: one low half, one high half, select high
          hc <= half_end ? '0 : hc + DIV_W'(1);
          if (half_end && !flash_clk) begin
            flash_clk <= 1'b1;
          end else if (half_end) begin
            done_tgl <= ~done_tgl;
            state    <= SFM_IDLE;
          end
        end
        default: begin
          state <= SFM_IDLE;
        end
      endcase
    end
  end

endmodule

// file: tb/sfm_port_props.sv
// Checker for the flash port pins and command handshake.
// Assumes it is bound to sfm_port; pins are watched on link_clock.
`timescale 1ns/1ps
module sfm_port_props (
  // Clocks, reset, freeze
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clock_en,
  input wire logic link_clock,
  // Command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic done,
  // Flash pins
  input wire logic flash_clk,
  input wire logic flash_chip_select_n,
  input wire logic flash_mosi
);
  logic [15:0] n_rise;
  // Rises while selected; must be whole bytes at the end
  always_ff @(posedge link_clock)
    if (flash_chip_select_n) n_rise <= 16'h0000;
    else if ($rose(flash_clk)) n_rise <= n_rise + 16'h0001;
  logic [7:0] quiet_cnt;
  // Link side leaves reset well after sys_rst falls; pins settle meanwhile
  always_ff @(posedge clock)
    if (sys_rst) quiet_cnt <= 8'h80;
    else if (quiet_cnt != 8'h00) quiet_cnt <= quiet_cnt - 8'h01;
  wire link_quiet = sys_rst || (quiet_cnt != 8'h00);
  // Half periods of three to five link cycles
  sequence low_half;  !flash_clk[*3] ##[1:3] flash_clk;  endsequence
  sequence high_half; flash_clk[*3] ##[1:3] !flash_clk;  endsequence
  low_half_a: assert property (
    @(posedge link_clock) disable iff (link_quiet)
    $fell(flash_clk) && !flash_chip_select_n |-> low_half)
    else $error("serial clock low phase out of range");
  high_half_a: assert property (
    @(posedge link_clock) disable iff (link_quiet)
    $rose(flash_clk) && !flash_chip_select_n |-> high_half)
    else $error("serial clock high phase out of range");
  mosi_fall_a: assert property (
    @(posedge link_clock) disable iff (link_quiet)
    $changed(flash_mosi) && !flash_chip_select_n |-> $fell(flash_clk))
    else $error("data out moved off a falling edge");
  select_fall_a: assert property (
    @(posedge link_clock) disable iff (link_quiet)
    $changed(flash_chip_select_n) |-> $fell(flash_clk))
    else $error("select moved off a falling edge");
  whole_bytes_a: assert property (
    @(posedge link_clock) disable iff (link_quiet)
    $rose(flash_chip_select_n) |-> n_rise[2:0] == 3'h0 && n_rise != 16'h0000)
    else $error("select released inside a byte");
  take_busy_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmd_valid && cmd_ready && clock_en |=> !cmd_ready)
    else $error("ready stayed high after a take");
  ready_done_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(cmd_ready) |-> done)
    else $error("ready returned without done");
  done_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    done |-> flash_chip_select_n)
    else $error("done while flash still selected");
endmodule
bind sfm_port sfm_port_props chk_u (.clock(clock), .sys_rst(sys_rst),
  .clock_en(clock_en), .link_clock(link_clock), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .done(done), .flash_clk(flash_clk),
  .flash_chip_select_n(flash_chip_select_n), .flash_mosi(flash_mosi));

// file: tb/sfm_flash_model.sv
// Behavioural serial flash; read byte k is address low byte plus k.
// Assumes clock-idle-high framing and a 24-bit address.
`timescale 1ns/1ps
module sfm_flash_model (
  // Pins from the port
  input  wire logic        flash_clk,
  input  wire logic        flash_chip_select_n,
  input  wire logic        flash_mosi,
  // Slow output mode, data after the rise
  input  wire logic        late,
  // Data back and capture record
  output logic             flash_miso,
  output logic [39:0]      shift_in,
  output logic [15:0]      n_bits
);
  logic [7:0] addr_lo;
  function automatic logic rd_bit(input logic [15:0] r);
    logic [7:0] d;
    d = addr_lo + 8'(r >> 3);
    rd_bit = d[3'h7 - r[2:0]];
  endfunction
  initial flash_miso = 1'b0;
  // New frame per select; released line flips so stale data never matches
  always @(negedge flash_chip_select_n) n_bits = 16'h0000;
  always @(posedge flash_chip_select_n) flash_miso <= ~flash_miso;
  // Capture on rise; slow mode answers 20 ns into the high phase
  always @(posedge flash_clk) if (!flash_chip_select_n) begin
    shift_in = {shift_in[38:0], flash_mosi};
    n_bits = n_bits + 16'h0001;
    if (n_bits == 16'h0020) addr_lo = shift_in[7:0];
    if (late && n_bits > 16'h0020) flash_miso <= #20 rd_bit(n_bits - 16'h0021);
  end
  // Normal answer shortly after the fall
  always @(negedge flash_clk)
    if (!flash_chip_select_n && !late && n_bits >= 16'h0020)
      flash_miso <= #2 rd_bit(n_bits - 16'h0020);
endmodule

// file: tb/sfm_port_tb.sv
// Bench for the serial flash port against the flash model.
// Assumes the checker binds itself to the port.
`timescale 1ns/1ps
module sfm_port_tb;
  import sfm_pkg::*;
  logic        clock, link_clock, sys_rst, clock_en, cmd_valid, late;
  logic        cmd_ready, done, f_clk, f_cs_n, f_mosi, f_miso;
  logic [39:0] seen;
  logic [15:0] nb;
  sfm_cmd_t    cmd;
  sfm_rx_t     rx;
  int          n_fail, tests_run;
  sfm_port dut_u (.clock(clock), .sys_rst(sys_rst), .clock_en(clock_en),
    .link_clock(link_clock), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rx(rx), .done(done), .flash_clk(f_clk),
    .flash_chip_select_n(f_cs_n), .flash_mosi(f_mosi), .flash_miso(f_miso));
  sfm_flash_model fm_u (.flash_clk(f_clk), .flash_chip_select_n(f_cs_n),
    .flash_mosi(f_mosi), .late(late), .flash_miso(f_miso),
    .shift_in(seen), .n_bits(nb));
  // Clocks, link clock off in phase
  initial begin clock = 0; forever #5 clock = ~clock; end
  initial begin link_clock = 0; #7; forever #32 link_clock = ~link_clock; end
  task automatic check(string what, logic [39:0] got, logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One whole transaction; port is idle on entry so first edge takes it
  task automatic xfer(logic [7:0] op, logic [23:0] ad, logic ae, logic we,
                      logic [15:0] len, logic [3:0] hd, logic lt, logic frz);
    int k, t;
    k = 0;
    @(negedge clock);
    late = lt;
    cmd = '{op, ad, ae, 8'hA5, we, len, hd};
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    check("busy", 40'(cmd_ready), 40'h0);
    // Freeze only rx counted while running
    if (frz) begin clock_en = 1'b0; repeat (20) @(negedge clock); end
    clock_en = 1'b1;
    for (t = 0; t < 20000 && done !== 1'b1; t++) begin
      @(negedge clock);
      if (rx.valid === 1'b1) begin
        check("rx byte", 40'(rx.data), 40'(ad[7:0] + 8'(k)));
        k++;
      end
    end
    check("done", 40'(done), 40'h1);
    if (done !== 1'b1) finish_test();
    check("ready", 40'(cmd_ready), 40'h1);
    check("idle pins", 40'({f_clk, f_cs_n}), 40'h3);
    check("rx count", 40'(k), 40'(len));
    check("bits", 40'(nb), 40'(8 * (1 + (ae ? 3 : 0) + we + len)));
  endtask
  task automatic t_write();
    xfer(8'h02, 24'h123456, 1'b1, 1'b1, 16'h0000, 4'h4, 1'b0, 1'b1);
    check("mosi", seen, 40'h02123456A5);
  endtask
  task automatic t_small();
    xfer(8'h03, 24'h01FFFC, 1'b1, 1'b0, 16'h0003, 4'h0, 1'b0, 1'b0);
  endtask
  task automatic t_big();
    xfer(8'h03, 24'hFFFFFD, 1'b1, 1'b0, 16'h0003, 4'hF, 1'b0, 1'b0);
  endtask
  task automatic t_late();
    xfer(8'h03, 24'h000080, 1'b1, 1'b0, 16'h0002, 4'h5, 1'b1, 1'b0);
  endtask
  task automatic t_single();
    xfer(8'h06, 24'h000000, 1'b0, 1'b0, 16'h0000, 4'h3, 1'b0, 1'b0);
    check("opcode", 40'(seen[7:0]), 40'h06);
  endtask
  // Short reset; the link side needs time to follow before any command
  initial begin
    n_fail = 0; tests_run = 0; late = 0; cmd = '0;
    clock_en = 1; cmd_valid = 0; sys_rst = 1;
    repeat (6) @(negedge clock);
    sys_rst = 0;
    repeat (150) @(negedge clock);
    t_write(); t_small(); t_big(); t_late(); t_single();
    finish_test();
  end
endmodule
